// ---- core/crp_pkg.sv ----
// Constants and state layout for the CPU register programming model.
// Assumes one clock domain and an AHB-Lite master in front of the block.
package crp_pkg;

  // ****************************************************************
  // Word index map (byte address = 4 * index)
  // ****************************************************************
  localparam logic [9:0] GPR_BASE = 10'h000;
  localparam logic [9:0] FPR_BASE = 10'h020;
  localparam logic [9:0] SRM_BASE = 10'h060;
  localparam logic [9:0] SRS_BASE = 10'h070;
  localparam logic [9:0] SPR_BASE = 10'h080;
  localparam logic [9:0] SPR_END = 10'h0AE;

  // ****************************************************************
  // Special register slots, offset from SPR_BASE
  // ****************************************************************
  localparam logic [5:0] S_CR = 6'h00;
  localparam logic [5:0] S_FLOAT_STATUS_CONTROL = 6'h01;
  localparam logic [5:0] S_XER = 6'h02;
  localparam logic [5:0] S_LR = 6'h03;
  localparam logic [5:0] S_CTR = 6'h04;
  localparam logic [5:0] S_MSR = 6'h05;
  localparam logic [5:0] S_FAULT_CAUSE_REG = 6'h06;
  localparam logic [5:0] S_DAR = 6'h07;
  localparam logic [5:0] S_DEC = 6'h08;
  localparam logic [5:0] S_PAGE_TABLE_BASE_REG = 6'h09;
  localparam logic [5:0] S_SAVE_RESTORE_PC = 6'h0A;
  localparam logic [5:0] S_SAVE_RESTORE_STATUS = 6'h0B;
  localparam logic [5:0] S_SPRG0 = 6'h0C;
  localparam logic [5:0] S_EAR = 6'h10;
  localparam logic [5:0] S_TBL = 6'h11;
  localparam logic [5:0] S_TBU = 6'h12;
  localparam logic [5:0] S_PVR = 6'h13;
  localparam logic [5:0] S_DBAT0 = 6'h14;
  localparam logic [5:0] S_IBAT0 = 6'h1C;
  localparam logic [5:0] S_DATA_XLATE_FAULT_ADDR = 6'h24;
  localparam logic [5:0] S_INSTR_XLATE_FAULT_ADDR = 6'h25;
  localparam logic [5:0] S_PRIMARY_GROUP_ADDR = 6'h26;
  localparam logic [5:0] S_SECONDARY_GROUP_ADDR = 6'h27;
  localparam logic [5:0] S_INSTR_PTE_MATCH_WORD = 6'h28;
  localparam logic [5:0] S_DATA_PTE_MATCH_WORD = 6'h29;
  localparam logic [5:0] S_RPA = 6'h2A;
  localparam logic [5:0] S_IMPL_CONFIG_REG0 = 6'h2B;
  localparam logic [5:0] S_IMPL_CONFIG_REG1 = 6'h2C;
  localparam logic [5:0] S_INSTR_BREAKPOINT_ADDR = 6'h2D;
  localparam int SPR_N = 46;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int MSR_PR_BIT = 14;
  localparam int XER_SO_BIT = 31;
  localparam int XER_OV_BIT = 30;
  localparam int XER_CA_BIT = 29;
  localparam int INSTR_BREAKPOINT_ADDR_EN_BIT = 1;
  localparam logic [31:0] DEC_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] ONE32 = 32'h0000_0001;
  localparam logic [63:0] TB_STEP = 64'h0000_0000_0000_0001;

  typedef struct packed {
    logic [SPR_N-1:0][31:0] spr;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic ap_act;
    logic ap_wr;
    logic [9:0] ap_idx;
    logic prog_exc;
    logic dec_exc;
    logic instr_breakpoint_addr_exc;
    logic bc_zero;
    logic [31:0] resume_pc;
    logic resume_vld;
  } crp_state_s;

endpackage

// ---- core/crp_regfile.sv ----
// Architectural register set of a 32-bit RISC core behind an AHB-Lite slave.
// Assumes core event inputs come from logic on hclk; one wait state per beat.
//
// Functional notes
// - Thirty-two 32-bit integer registers, source and destination of integer work.
// - Thirty-two 64-bit floating registers holding single or double values.
// - Condition flags register is 32 bits as eight 4-bit fields.
// - Machine state word saved on exception, restored on interrupt return.
// - Sixteen segment registers kept as main and shadow copies.
// - Segment load writes main and shadow copies at the same entry.
// - Every special register is 32 bits; time counter is two halves.
// - Link register supplies targets and captures return addresses on branch-link.
// - Branch count register decrements and is tested on branch-and-count.
// - Integer exception flags hold sticky summary, carry, overflow and byte count.
// - Alignment or storage fault records cause and faulting address.
// - Countdown timer decrements and raises an exception after its delay.
// - Exception saves instruction address; interrupt return resumes there.
// - Exception saves machine status; interrupt return restores it.
// - Time counter is 64 bits with separately accessible halves.
// - Version register is read-only; writes leave it unchanged.
// - Sixteen block translation registers: four data and four instruction pairs.
// - Translation misses load the read-only miss address registers.
// - Two hash address registers hold primary and secondary group addresses.
// - Table search loads match words and found second word.
// - Breakpoint register compared to dispatch addresses, raising an exception on match.
// - Supervisor-only resources usable only when the user-level flag is clear.
module crp_regfile
  import crp_pkg::*;
#(
  // Value is arbitrary.
  parameter logic [31:0] VERSION_ID = 32'h0001_0001
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic exc_take,
  input wire logic [31:0] exc_pc,
  input wire logic exc_fault,
  input wire logic [31:0] fault_cause,
  input wire logic [31:0] fault_addr,
  input wire logic interrupt_return_op,
  input wire logic bl,
  input wire logic [31:0] bl_ret,
  input wire logic bc,
  input wire logic seg_load,
  input wire logic [3:0] seg_idx,
  input wire logic [31:0] seg_data,
  input wire logic cr_upd,
  input wire logic [2:0] cr_field,
  input wire logic [3:0] cr_val,
  input wire logic xer_upd,
  input wire logic xer_ov,
  input wire logic xer_ca,
  input wire logic itlb_miss,
  input wire logic dtlb_miss,
  input wire logic [31:0] miss_addr,
  input wire logic tsearch,
  input wire logic [31:0] primary_group_addr_in,
  input wire logic [31:0] secondary_group_addr_in,
  input wire logic [31:0] pte_word0,
  input wire logic found,
  input wire logic [31:0] pte_word1,
  input wire logic disp_vld,
  input wire logic [31:0] disp_pc,
  output logic [31:0] msr_out,
  output logic [31:0] lr_out,
  output logic [31:0] resume_pc,
  output logic resume_vld,
  output logic bc_zero,
  output logic dec_exc,
  output logic instr_breakpoint_addr_exc,
  output logic prog_exc
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  crp_state_s r;
  crp_state_s n;
  logic [31:0] gpr_mem [32];
  logic [63:0] fpr_mem [32];
  logic [31:0] srm_mem [16];
  logic [31:0] srs_mem [16];
  logic user;
  logic wr_ok;
  logic sw_spr;
  logic [5:0] sw_s;
  logic [31:0] rd_val;
  logic [5:0] fpr_off;

  function automatic logic spr_ro(input logic [5:0] s);
    return s == S_PVR || s == S_DATA_XLATE_FAULT_ADDR || s == S_INSTR_XLATE_FAULT_ADDR ||
           s == S_PRIMARY_GROUP_ADDR || s == S_SECONDARY_GROUP_ADDR;
  endfunction

  // User mode may touch the operand files, the user-level special
  // registers and read the time counter; everything else below SPR_END traps.
  function automatic logic user_ok(input logic [9:0] idx,
                                   input logic wr, input logic usr);
    logic [5:0] s;
    s = 6'(idx - SPR_BASE);
    if (!usr || idx < SRM_BASE || idx >= SPR_END) begin
      return 1'b1;
    end
    if (idx < SPR_BASE) begin
      return 1'b0;
    end
    case (s)
      S_CR, S_FLOAT_STATUS_CONTROL, S_XER, S_LR, S_CTR: return 1'b1;
      S_TBL, S_TBU: return !wr;
      default: return 1'b0;
    endcase
  endfunction

  assign user = r.spr[S_MSR][MSR_PR_BIT];
  assign fpr_off = 6'(r.ap_idx - FPR_BASE);
  assign sw_s = 6'(r.ap_idx - SPR_BASE);

  // ****************************************************************
  // Read path of the data phase
  // ****************************************************************
  always_comb begin
    rd_val = 32'h0000_0000;
    if (r.ap_idx < FPR_BASE) begin
      rd_val = gpr_mem[r.ap_idx[4:0]];
    end else if (r.ap_idx < SRM_BASE) begin
      rd_val = fpr_off[0] ? fpr_mem[fpr_off[5:1]][63:32]
                          : fpr_mem[fpr_off[5:1]][31:0];
    end else if (r.ap_idx < SRS_BASE) begin
      rd_val = srm_mem[r.ap_idx[3:0]];
    end else if (r.ap_idx < SPR_BASE) begin
      rd_val = srs_mem[r.ap_idx[3:0]];
    end else if (r.ap_idx < SPR_END) begin
      rd_val = r.spr[sw_s];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.prog_exc = 1'b0;
    n.dec_exc = 1'b0;
    n.instr_breakpoint_addr_exc = 1'b0;
    n.resume_vld = 1'b0;
    n.hresp = 1'b0;
    wr_ok = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.ap_act = 1'b1;
      n.ap_idx = haddr[11:2];
      n.ap_wr = hwrite;
      n.hready = 1'b0;
    end else if (r.ap_act) begin
      n.ap_act = 1'b0;
      n.hready = 1'b1;
      n.hrdata = 32'h0000_0000;
      if (!user_ok(r.ap_idx, r.ap_wr, user)) begin
        n.prog_exc = 1'b1;
      end else if (r.ap_wr) begin
        wr_ok = 1'b1;
      end else begin
        n.hrdata = rd_val;
      end
    end
    sw_spr = wr_ok && r.ap_idx >= SPR_BASE && r.ap_idx < SPR_END &&
             !spr_ro(sw_s);
    if (sw_spr) begin
      n.spr[sw_s] = hwdata;
    end
    // Core events follow the bus write so that they win; a bus write to the time counter or DEC overrides its step.
    if (!(sw_spr && (sw_s == S_TBL || sw_s == S_TBU))) begin
      {n.spr[S_TBU], n.spr[S_TBL]} =
        {r.spr[S_TBU], r.spr[S_TBL]} + TB_STEP;
    end
    if (!(sw_spr && sw_s == S_DEC)) begin
      n.spr[S_DEC] = r.spr[S_DEC] - ONE32;
      n.dec_exc = r.spr[S_DEC] == 32'h0000_0000;
    end
    if (bl) begin
      n.spr[S_LR] = bl_ret;
    end
    if (bc) begin
      n.spr[S_CTR] = r.spr[S_CTR] - ONE32;
      n.bc_zero = r.spr[S_CTR] == ONE32;
    end
    if (cr_upd) begin
      n.spr[S_CR][{~cr_field, 2'b00} +: 4] = cr_val;
    end
    if (xer_upd) begin
      n.spr[S_XER][XER_OV_BIT] = xer_ov;
      n.spr[S_XER][XER_CA_BIT] = xer_ca;
      if (xer_ov) begin
        n.spr[S_XER][XER_SO_BIT] = 1'b1;
      end
    end
    if (itlb_miss) begin
      n.spr[S_INSTR_XLATE_FAULT_ADDR] = miss_addr;
    end
    if (dtlb_miss) begin
      n.spr[S_DATA_XLATE_FAULT_ADDR] = miss_addr;
    end
    if (tsearch) begin
      n.spr[S_PRIMARY_GROUP_ADDR] = primary_group_addr_in;
      n.spr[S_SECONDARY_GROUP_ADDR] = secondary_group_addr_in;
      n.spr[S_INSTR_PTE_MATCH_WORD] = pte_word0;
      n.spr[S_DATA_PTE_MATCH_WORD] = pte_word0;
      if (found) begin
        n.spr[S_RPA] = pte_word1;
      end
    end
    if (exc_take) begin
      n.spr[S_SAVE_RESTORE_PC] = exc_pc;
      n.spr[S_SAVE_RESTORE_STATUS] = r.spr[S_MSR];
      n.spr[S_MSR][MSR_PR_BIT] = 1'b0;
      if (exc_fault) begin
        n.spr[S_FAULT_CAUSE_REG] = fault_cause;
        n.spr[S_DAR] = fault_addr;
      end
    end else if (interrupt_return_op) begin
      n.spr[S_MSR] = r.spr[S_SAVE_RESTORE_STATUS];
      n.resume_pc = r.spr[S_SAVE_RESTORE_PC];
      n.resume_vld = 1'b1;
    end
    if (disp_vld && r.spr[S_INSTR_BREAKPOINT_ADDR][INSTR_BREAKPOINT_ADDR_EN_BIT] &&
        disp_pc[31:2] == r.spr[S_INSTR_BREAKPOINT_ADDR][31:2]) begin
      n.instr_breakpoint_addr_exc = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hready <= 1'b1;
      r.spr[S_DEC] <= DEC_RST;
      r.spr[S_PVR] <= VERSION_ID;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Operand and segment arrays
  // ****************************************************************
  always_ff @(posedge hclk) begin
    if (wr_ok && r.ap_idx < FPR_BASE) begin
      gpr_mem[r.ap_idx[4:0]] <= hwdata;
    end
    if (wr_ok && r.ap_idx >= FPR_BASE && r.ap_idx < SRM_BASE) begin
      if (fpr_off[0]) begin
        fpr_mem[fpr_off[5:1]][63:32] <= hwdata;
      end else begin
        fpr_mem[fpr_off[5:1]][31:0] <= hwdata;
      end
    end
    if (seg_load) begin
      srm_mem[seg_idx] <= seg_data;
      srs_mem[seg_idx] <= seg_data;
    end else if (wr_ok && r.ap_idx >= SRM_BASE &&
                 r.ap_idx < SRS_BASE) begin
      srm_mem[r.ap_idx[3:0]] <= hwdata;
      srs_mem[r.ap_idx[3:0]] <= hwdata;
    end
  end

  assign hreadyout = r.hready;
  assign hresp = r.hresp;
  assign hrdata = r.hrdata;
  assign msr_out = r.spr[S_MSR];
  assign lr_out = r.spr[S_LR];
  assign resume_pc = r.resume_pc;
  assign resume_vld = r.resume_vld;
  assign bc_zero = r.bc_zero;
  assign dec_exc = r.dec_exc;
  assign instr_breakpoint_addr_exc = r.instr_breakpoint_addr_exc;
  assign prog_exc = r.prog_exc;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence addr_ph;
    hsel && htrans[1] && hready;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  bus_wait_a: assert property (addr_ph |=> one_wait)
    else $error("slave did not answer after one wait");
  link_capture_a: assert property (bl |=> lr_out == $past(bl_ret))
    else $error("link register missed return address");
  count_dec_a: assert property (bc && !(sw_spr && sw_s == S_CTR) |=>
    r.spr[S_CTR] == $past(r.spr[S_CTR]) - ONE32 &&
    bc_zero == (r.spr[S_CTR] == 32'h0000_0000))
    else $error("count register not decremented and tested");
  dec_wrap_a: assert property (r.spr[S_DEC] == 32'h0000_0000 &&
    !(sw_spr && sw_s == S_DEC) |=> dec_exc && r.spr[S_DEC] == DEC_RST)
    else $error("countdown expiry not signalled");
  exc_save_a: assert property (exc_take |=> r.spr[S_SAVE_RESTORE_PC] ==
    $past(exc_pc) && r.spr[S_SAVE_RESTORE_STATUS] == $past(msr_out) && !user)
    else $error("exception state not saved");
  rfi_restore_a: assert property (interrupt_return_op && !exc_take |=>
    msr_out == $past(r.spr[S_SAVE_RESTORE_STATUS]) && resume_vld &&
    resume_pc == $past(r.spr[S_SAVE_RESTORE_PC]))
    else $error("interrupt return did not restore");
  seg_both_a: assert property (seg_load |=>
    srm_mem[$past(seg_idx)] == $past(seg_data) &&
    srs_mem[$past(seg_idx)] == $past(seg_data))
    else $error("segment copies differ after load");
  version_ro_a: assert property (r.spr[S_PVR] == VERSION_ID)
    else $error("version register changed");
  sequence trap_out;
    prog_exc && hrdata == 32'h0000_0000;
  endsequence
  priv_trap_a: assert property (r.ap_act && user &&
    !user_ok(r.ap_idx, r.ap_wr, 1'b1) |-> !wr_ok ##1 trap_out)
    else $error("user access to supervisor register not trapped");
  tb_count_a: assert property (hresetn && !(sw_spr &&
    (sw_s == S_TBL || sw_s == S_TBU)) |=> {r.spr[S_TBU], r.spr[S_TBL]} ==
    $past({r.spr[S_TBU], r.spr[S_TBL]}) + TB_STEP)
    else $error("time counter did not advance");
  instr_breakpoint_addr_hit_a: assert property (disp_vld && r.spr[S_INSTR_BREAKPOINT_ADDR][INSTR_BREAKPOINT_ADDR_EN_BIT] &&
    disp_pc[31:2] == r.spr[S_INSTR_BREAKPOINT_ADDR][31:2] |=> instr_breakpoint_addr_exc)
    else $error("breakpoint match not raised");

  // ****************************************************************
  // Core event, supervisor access and bus response checks
  // ****************************************************************
  cr_field_a: assert property (cr_upd |=>
    4'(r.spr[S_CR] >> (5'd28 - {$past(cr_field), 2'b00})) == $past(cr_val))
    else $error("condition field not written");
  xer_sticky_a: assert property (xer_upd && xer_ov |=>
    r.spr[S_XER][XER_SO_BIT] && r.spr[S_XER][XER_OV_BIT] &&
    r.spr[S_XER][XER_CA_BIT] == $past(xer_ca))
    else $error("integer exception flags not recorded");
  so_hold_a: assert property (xer_upd &&
    r.spr[S_XER][XER_SO_BIT] && !(sw_spr && sw_s == S_XER) |=>
    r.spr[S_XER][XER_SO_BIT])
    else $error("summary overflow not sticky");
  data_xlate_fault_addr_load_a: assert property (dtlb_miss |=>
    r.spr[S_DATA_XLATE_FAULT_ADDR] == $past(miss_addr))
    else $error("data miss address not loaded");
  instr_xlate_fault_addr_load_a: assert property (itlb_miss |=>
    r.spr[S_INSTR_XLATE_FAULT_ADDR] == $past(miss_addr))
    else $error("instruction miss address not loaded");
  fault_rec_a: assert property (exc_take && exc_fault |=>
    r.spr[S_FAULT_CAUSE_REG] == $past(fault_cause) &&
    r.spr[S_DAR] == $past(fault_addr))
    else $error("fault cause or address not recorded");
  hash_load_a: assert property (tsearch |=>
    r.spr[S_PRIMARY_GROUP_ADDR] == $past(primary_group_addr_in) &&
    r.spr[S_SECONDARY_GROUP_ADDR] == $past(secondary_group_addr_in))
    else $error("hash addresses not loaded");
  pte_match_a: assert property (tsearch && !sw_spr |=>
    r.spr[S_INSTR_PTE_MATCH_WORD] == $past(pte_word0) &&
    r.spr[S_DATA_PTE_MATCH_WORD] == $past(pte_word0) &&
    r.spr[S_RPA] ==
    ($past(found) ? $past(pte_word1) : $past(r.spr[S_RPA])))
    else $error("table search words not loaded");
  dec_step_a: assert property (hresetn && !(sw_spr &&
    sw_s == S_DEC) && r.spr[S_DEC] != 32'h0000_0000 |=>
    r.spr[S_DEC] == $past(r.spr[S_DEC]) - ONE32 && !dec_exc)
    else $error("countdown did not step");
  super_ok_a: assert property (r.ap_act && !user |=> !prog_exc)
    else $error("supervisor access trapped");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("slave answered with an error");

endmodule // crp_regfile

// ---- sim/crp_regfile_tb_top.sv ----
// Self-checking bench for the register file and its AHB-Lite slave port.
// Assumes the bench is the only bus master and drives every core event.
module crp_regfile_tb_top
  import crp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // Signals
  // ********
  // Value is arbitrary.
  localparam logic [31:0] VER = 32'h0000_0042;
  localparam int LIMIT = 5000;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic exc_take, exc_fault, interrupt_return_op, bl, bc, seg_load, cr_upd, xer_upd;
  logic xer_ov, xer_ca, itlb_miss, dtlb_miss, tsearch, found, disp_vld;
  logic resume_vld, bc_zero, dec_exc, instr_breakpoint_addr_exc, prog_exc;
  logic [1:0] htrans;
  logic [2:0] hsize, cr_field;
  logic [3:0] seg_idx, cr_val;
  logic [31:0] haddr, hwdata, hrdata, exc_pc, fault_cause, fault_addr;
  logic [31:0] bl_ret, seg_data, miss_addr, primary_group_addr_in, secondary_group_addr_in, pte_word0;
  logic [31:0] pte_word1, disp_pc, msr_out, lr_out, resume_pc;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int np = 0;
  int nd = 0;
  int ni = 0;
  int nr = 0;

  assign hready = hreadyout;

  crp_regfile #(.VERSION_ID(VER)) u_crp_regfile (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .exc_take(exc_take), .exc_pc(exc_pc),
    .exc_fault(exc_fault), .fault_cause(fault_cause),
    .fault_addr(fault_addr), .interrupt_return_op(interrupt_return_op), .bl(bl), .bl_ret(bl_ret),
    .bc(bc), .seg_load(seg_load), .seg_idx(seg_idx),
    .seg_data(seg_data), .cr_upd(cr_upd), .cr_field(cr_field),
    .cr_val(cr_val), .xer_upd(xer_upd), .xer_ov(xer_ov),
    .xer_ca(xer_ca), .itlb_miss(itlb_miss), .dtlb_miss(dtlb_miss),
    .miss_addr(miss_addr), .tsearch(tsearch), .primary_group_addr_in(primary_group_addr_in),
    .secondary_group_addr_in(secondary_group_addr_in), .pte_word0(pte_word0), .found(found),
    .pte_word1(pte_word1), .disp_vld(disp_vld), .disp_pc(disp_pc),
    .msr_out(msr_out), .lr_out(lr_out), .resume_pc(resume_pc),
    .resume_vld(resume_vld), .bc_zero(bc_zero), .dec_exc(dec_exc),
    .instr_breakpoint_addr_exc(instr_breakpoint_addr_exc), .prog_exc(prog_exc)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Pulse outputs stand one cycle, so they are counted as they pass.
  always @(posedge hclk) begin
    cyc++;
    np += int'(prog_exc === 1'b1);
    nd += int'(dec_exc === 1'b1);
    ni += int'(instr_breakpoint_addr_exc === 1'b1);
    nr += int'(resume_vld === 1'b1);
    if (cyc == LIMIT) begin
      failures++;
      final_report();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  function automatic logic [9:0] sp(input logic [5:0] s);
    return SPR_BASE + {4'h0, s};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    {hsel, hwrite, exc_take, exc_fault, interrupt_return_op, bl, bc, seg_load} = '0;
    {cr_upd, xer_upd, xer_ov, xer_ca, itlb_miss, dtlb_miss} = '0;
    {tsearch, found, disp_vld, htrans, cr_field, seg_idx, cr_val} = '0;
    {haddr, hwdata, exc_pc, fault_cause, fault_addr, bl_ret} = '0;
    {seg_data, miss_addr, primary_group_addr_in, secondary_group_addr_in, pte_word0} = '0;
    {pte_word1, disp_pc} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(sp(S_MSR), 32'h0000_0000);
    rd(sp(S_PVR), VER);
    wr(sp(S_PVR), 32'h0000_0000);
    rd(sp(S_PVR), VER);
    wr(10'h0AE, 32'h1111_1111);
    rd(10'h0AE, 32'h0000_0000);
    for (int i = 0; i < 32; i += 31) begin
      wr(GPR_BASE + 10'(i), 32'hA5A5_0000 + 32'(i));
      wr(FPR_BASE + 10'(2 * i), 32'h0F0F_0000 + 32'(i));
      wr(FPR_BASE + 10'(2 * i + 1), 32'h5A5A_0000 + 32'(i));
    end
    for (int i = 0; i < 32; i += 31) begin
      rd(GPR_BASE + 10'(i), 32'hA5A5_0000 + 32'(i));
      rd(FPR_BASE + 10'(2 * i), 32'h0F0F_0000 + 32'(i));
      rd(FPR_BASE + 10'(2 * i + 1), 32'h5A5A_0000 + 32'(i));
    end
    {seg_load, seg_idx, seg_data} <= {1'b1, 4'd3, 32'h1234_5678};
    step(1);
    seg_load <= 1'b0;
    rd(SRM_BASE + 10'h003, 32'h1234_5678);
    rd(SRS_BASE + 10'h003, 32'h1234_5678);
    wr(SRM_BASE + 10'h00F, 32'hCAFE_0001);
    wr(SRS_BASE + 10'h00F, 32'h0000_0000);
    rd(SRS_BASE + 10'h00F, 32'hCAFE_0001);
    {bl, bl_ret} <= {1'b1, 32'h0000_0104};
    step(1);
    bl <= 1'b0;
    rd(sp(S_LR), 32'h0000_0104);
    chk(lr_out, 32'h0000_0104);
    wr(sp(S_CTR), 32'h0000_0002);
    bc <= 1'b1;
    step(1);
    bc <= 1'b0;
    rd(sp(S_CTR), 32'h0000_0001);
    chk({31'h0, bc_zero}, 32'h0000_0000);
    bc <= 1'b1;
    step(1);
    bc <= 1'b0;
    step(2);
    chk({31'h0, bc_zero}, 32'h0000_0001);
    {cr_upd, cr_field, cr_val} <= {1'b1, 3'd0, 4'hA};
    step(1);
    {cr_field, cr_val} <= {3'd7, 4'h5};
    step(1);
    cr_upd <= 1'b0;
    rd(sp(S_CR), 32'hA000_0005);
    {xer_upd, xer_ov, xer_ca} <= 3'b111;
    step(1);
    {xer_ov, xer_ca} <= 2'b00;
    step(1);
    xer_upd <= 1'b0;
    rd(sp(S_XER), 32'h8000_0000);
    wr(sp(S_SPRG0), 32'h0000_5A5A);
    wr(sp(S_MSR), 32'h0000_C030);
    step(1);
    chk(msr_out, 32'h0000_C030);
    rd(GPR_BASE, 32'hA5A5_0000);
    rd(sp(S_SPRG0), 32'h0000_0000);
    wr(sp(S_SPRG0), 32'h0000_1111);
    {exc_take, exc_fault, exc_pc} <= {2'b11, 32'h0000_1000};
    {fault_cause, fault_addr} <= {32'h0200_0000, 32'h0BAD_0004};
    step(1);
    {exc_take, exc_fault} <= 2'b00;
    step(2);
    chk(32'(np), 32'h0000_0002);
    chk(msr_out, 32'h0000_8030);
    rd(sp(S_SAVE_RESTORE_PC), 32'h0000_1000);
    rd(sp(S_SAVE_RESTORE_STATUS), 32'h0000_C030);
    rd(sp(S_FAULT_CAUSE_REG), 32'h0200_0000);
    rd(sp(S_DAR), 32'h0BAD_0004);
    rd(sp(S_SPRG0), 32'h0000_5A5A);
    interrupt_return_op <= 1'b1;
    step(1);
    interrupt_return_op <= 1'b0;
    step(2);
    chk(msr_out, 32'h0000_C030);
    chk(resume_pc, 32'h0000_1000);
    chk(32'(nr), 32'h0000_0001);
    {exc_take, exc_pc} <= {1'b1, 32'h0000_2000};
    step(1);
    exc_take <= 1'b0;
    rd(sp(S_SAVE_RESTORE_PC), 32'h0000_2000);
    rd(sp(S_FAULT_CAUSE_REG), 32'h0200_0000);
    wr(sp(S_DEC), 32'h0000_0003);
    step(8);
    chk(32'(nd), 32'h0000_0001);
    wr(sp(S_TBU), 32'h0000_0005);
    rd(sp(S_TBU), 32'h0000_0005);
    wr(sp(S_TBL), 32'hFFFF_FFF0);
    step(20);
    rd(sp(S_TBU), 32'h0000_0006);
    wr(sp(S_DBAT0), 32'h0DBA_7001);
    wr(sp(S_IBAT0 + 6'h07), 32'h01BA_7007);
    rd(sp(S_DBAT0), 32'h0DBA_7001);
    rd(sp(S_IBAT0 + 6'h07), 32'h01BA_7007);
    wr(sp(S_INSTR_BREAKPOINT_ADDR), 32'h0000_2002);
    {disp_vld, disp_pc} <= {1'b1, 32'h0000_2000};
    step(1);
    disp_pc <= 32'h0000_2004;
    step(1);
    disp_vld <= 1'b0;
    step(2);
    chk(32'(ni), 32'h0000_0001);
    {dtlb_miss, miss_addr} <= {1'b1, 32'h0000_3000};
    step(1);
    {dtlb_miss, itlb_miss, miss_addr} <= {2'b01, 32'h0000_4000};
    step(1);
    itlb_miss <= 1'b0;
    wr(sp(S_DATA_XLATE_FAULT_ADDR), 32'h0000_0000);
    rd(sp(S_DATA_XLATE_FAULT_ADDR), 32'h0000_3000);
    rd(sp(S_INSTR_XLATE_FAULT_ADDR), 32'h0000_4000);
    {primary_group_addr_in, secondary_group_addr_in} <= {32'h0000_5000, 32'h0000_6000};
    {pte_word0, pte_word1} <= {32'h8000_1234, 32'h0000_0192};
    {tsearch, found} <= 2'b11;
    step(1);
    {tsearch, found} <= 2'b00;
    rd(sp(S_PRIMARY_GROUP_ADDR), 32'h0000_5000);
    rd(sp(S_SECONDARY_GROUP_ADDR), 32'h0000_6000);
    rd(sp(S_INSTR_PTE_MATCH_WORD), 32'h8000_1234);
    rd(sp(S_DATA_PTE_MATCH_WORD), 32'h8000_1234);
    rd(sp(S_RPA), 32'h0000_0192);
    {tsearch, pte_word1} <= {1'b1, 32'h0000_0BAD};
    step(1);
    tsearch <= 1'b0;
    rd(sp(S_RPA), 32'h0000_0192);
    step(2);
    final_report();
  end

endmodule // crp_regfile_tb_top
